//--- flt_conv_map.vh
// operation codes, field positions and format constants of the float/fixed converter
// assumes: included by bare name from the converter sources
`ifndef FLT_CONV_MAP_VH
`define FLT_CONV_MAP_VH

`define OP_W 4
`define OP_HALF_DEC 4'h0
`define OP_UF11_DEC 4'h1
`define OP_UF10_DEC 4'h2
`define OP_UF11_ENC 4'h3
`define OP_UF10_ENC 4'h4
`define OP_FIX_TO_F 4'h5
`define OP_UNORM_TO_F 4'h6
`define OP_SNORM_TO_F 4'h7
`define OP_F_TO_UNORM 4'h8
`define OP_F_TO_SNORM 4'h9
`define OP_F_TO_FIX 4'ha

`define HALF_SIGN_BIT 15
`define HALF_EXP_HI 14
`define HALF_EXP_LO 10
`define HALF_MAN_HI 9
`define UF11_EXP_HI 10
`define UF11_EXP_LO 6
`define UF11_MAN_HI 5
`define UF10_EXP_HI 9
`define UF10_EXP_LO 5
`define UF10_MAN_HI 4
`define UF11_MAN_W 6
`define UF10_MAN_W 5
`define SMALL_EXP_SPECIAL 5'h1f

`define F32_EXP_SPECIAL 8'hff
`define F32_BIAS 127
`define F32_MAN_W 23
`define F32_QNAN_BIT 22
`define F32_ONE 32'h3f800000
`define F32_NEG_ONE 32'hbf800000
`define F32_DENORM_EXP0 8'h67
`define SMALL_TO_F32_REBIAS 8'h70
`define SMALL_REBIAS 112

`define UF11_MAX_FINITE 11'h7bf
`define UF11_POS_INF 11'h7c0
`define UF11_NAN 11'h7e0
`define UF10_MAX_FINITE 10'h3df
`define UF10_POS_INF 10'h3e0
`define UF10_NAN 10'h3f0
`define SMALL_EXP_MAX_FINITE 30

`define FIX_FRAC_BITS 6'h10
`define FIX_SAT_EXP 142
`define FIX_POS_MAX 32'h7fffffff
`define FIX_NEG_MAX 32'h80000000

`define NORM_MAX_BITS 5'h10
`define NORM_MIN_BITS 5'h01
`define NORM_MIN_ALPHA 5'h02
`define NORM_MIN_SIGNED 5'h02
`define NORM_FRAC_BITS 6'h20
`define ROUND_HALF 64'h0000000080000000

`define RESULT_RST 32'h00000000

`endif

//--- small_float_decode.v
// decodes a five-bit-exponent small float (sign, exponent, ten-bit left-aligned mantissa) to single precision
// assumes: purely combinational; unsigned formats drive sign low and pad the mantissa with zeros
`timescale 1ns/10ps
`default_nettype none
`include "flt_conv_map.vh"

module small_float_decode (
  input wire i_sign,
  input wire [4:0] i_exp,
  input wire [9:0] i_man,
  output reg [31:0] o_f32
);

  integer k;
  reg [3:0] lead;
  reg [10:0] wide;

  always @* begin
    lead = 4'h0;
    for (k = 0; k < 10; k = k + 1) begin
      if (i_man[k]) begin
        lead = k[3:0];
      end
    end
    wide = {1'b0, i_man} << (4'ha - lead);
    if (i_exp == 5'h00 && i_man == 10'h000) begin
      o_f32 = {i_sign, 31'h0}; // RULE2 RULE4
    end else if (i_exp == 5'h00) begin
      o_f32 = {i_sign, `F32_DENORM_EXP0 + {4'h0, lead}, wide[9:0], 13'h0}; // RULE2 RULE4
    end else if (i_exp == `SMALL_EXP_SPECIAL && i_man == 10'h000) begin
      o_f32 = {i_sign, `F32_EXP_SPECIAL, 23'h0}; // RULE2
    end else if (i_exp == `SMALL_EXP_SPECIAL) begin
      o_f32 = {i_sign, `F32_EXP_SPECIAL, 1'b1, i_man[8:0], 13'h0}; // RULE2 RULE4
    end else begin
      o_f32 = {i_sign, {3'h0, i_exp} + `SMALL_TO_F32_REBIAS, i_man, 13'h0}; // RULE1 RULE2
    end
  end

endmodule
`default_nettype wire

//--- packed_float_fixed_converter.v
// one-stage float/fixed format converter: half floats to single; unsigned small floats, 16.16 fixed and normalized integers to and from single
// assumes: one clock, synchronous active-high reset, every operation accepted every cycle with one cycle latency
//
// Summary of operation
// [RULE1] half float is one sign bit, five exponent bits, ten mantissa bits
// [RULE2] half decode: zero, denormal times 2^-14, normal bias 15, exponent 31 infinity or NaN
// [RULE3] half word: sign bit 15, exponent bits 14..10, mantissa bits 9..0
// [RULE4] denormals and negative zero decode predictably; infinity and NaN never stall
// [RULE5] eleven-bit unsigned float: five exponent, six mantissa bits, same decode cases
// [RULE6] eleven-bit float: exponent upper five bits; denormal is mantissa/64 times 2^-14
// [RULE7] encoding to unsigned small floats rounds to nearest; negative finite gives zero
// [RULE8] eleven-bit encode saturates large finite values to 65024
// [RULE9] ten-bit encode saturates large finite values to 64512
// [RULE10] encode specials: minus infinity to zero, plus infinity kept, any NaN positive NaN
// [RULE11] ten-bit float: five exponent upper bits, five mantissa; denormal mantissa/32 times 2^-14
// [RULE12] fixed inputs are 32-bit two's complement with sixteen fraction bits
// [RULE13] division by zero gives any value but never stalls the datapath
// [RULE14] unsigned normalized to float divides by 2^b minus one
// [RULE15] signed normalized to float divides by 2^(b-1) minus one, clamped at -1
// [RULE16] alpha width is at least two when no alpha or one alpha bit
// [RULE17] normalized conversions use nominal width b, not the storage width
// [RULE18] internal arithmetic single precision; zero and one cases exact
// [RULE19] any representable float input is legal
// [RULE20] float to unsigned normalized: clamp 0..1, times 2^b minus one, cast
// [RULE21] float to signed normalized: clamp -1..1, times 2^(b-1) minus one, cast
// [RULE22] final integer cast rounds to nearest so endpoints map back exactly
`timescale 1ns/10ps
`default_nettype none
`include "flt_conv_map.vh"

module packed_float_fixed_converter (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_valid,
  input wire [3:0] i_op,
  input wire [31:0] i_data,
  input wire [4:0] i_width,
  input wire i_alpha_min2,
  output wire o_valid,
  output wire [31:0] o_result
);

  reg o_valid_r;
  reg [31:0] o_result_r;
  reg [31:0] result_nxt;

  // value = mag * 2^-scale, truncated to single precision
  function [31:0] mag_to_f32(input [31:0] mag, input sgn, input [5:0] scale);
    integer k;
    integer p;
    integer ex;
    reg [31:0] sh;
    begin
      p = 0;
      for (k = 0; k < 32; k = k + 1) begin
        if (mag[k]) begin
          p = k;
        end
      end
      ex = p + `F32_BIAS - scale;
      sh = mag << (31 - p);
      if (mag == 32'h0) begin
        mag_to_f32 = {sgn, 31'h0};
      end else begin
        mag_to_f32 = {sgn, ex[7:0], sh[30:8]};
      end
    end
  endfunction

  // c/(2^w-1) as a 32-bit binary fraction: the w-bit pattern repeated
  function [31:0] rep_frac(input [31:0] c, input [4:0] w);
    integer k;
    reg [63:0] acc;
    begin
      acc = 64'h0;
      for (k = 0; k < 32; k = k + 1) begin
        acc = acc | ({c, 32'h0} >> ((k + 1) * w));
      end
      rep_frac = acc[31:0];
    end
  endfunction

  // width selection
  reg [4:0] w_lim;
  reg [4:0] w_u;
  reg [4:0] w_s;
  reg [32:0] mask_u_w;
  reg [32:0] mask_s_w;
  reg [31:0] mask_u;
  reg [31:0] mask_s;

  always @* begin
    w_lim = i_width;
    if (i_width < `NORM_MIN_BITS) begin
      w_lim = `NORM_MIN_BITS;
    end else if (i_width > `NORM_MAX_BITS) begin
      w_lim = `NORM_MAX_BITS;
    end
    w_u = w_lim;
    if (i_alpha_min2 && w_lim < `NORM_MIN_ALPHA) begin
      w_u = `NORM_MIN_ALPHA; // RULE16
    end
    w_s = (w_u < `NORM_MIN_SIGNED) ? `NORM_MIN_SIGNED : w_u;
    mask_u_w = (33'h1 << w_u) - 33'h1; // RULE17
    mask_s_w = (33'h1 << w_s) - 33'h1; // RULE17
    mask_u = mask_u_w[31:0];
    mask_s = mask_s_w[31:0];
  end

  // small float decode (half, eleven-bit, ten-bit share one decoder)
  reg dec_sign;
  reg [4:0] dec_exp;
  reg [9:0] dec_man;
  wire [31:0] dec_f32;

  always @* begin
    dec_sign = 1'b0;
    dec_exp = i_data[`HALF_EXP_HI:`HALF_EXP_LO];
    dec_man = i_data[`HALF_MAN_HI:0];
    if (i_op == `OP_HALF_DEC) begin
      dec_sign = i_data[`HALF_SIGN_BIT]; // RULE3
    end else if (i_op == `OP_UF11_DEC) begin
      dec_exp = i_data[`UF11_EXP_HI:`UF11_EXP_LO]; // RULE5 RULE6
      dec_man = {i_data[`UF11_MAN_HI:0], 4'h0}; // RULE6
    end else begin
      dec_exp = i_data[`UF10_EXP_HI:`UF10_EXP_LO]; // RULE11
      dec_man = {i_data[`UF10_MAN_HI:0], 5'h00}; // RULE11
    end
  end

  small_float_decode u_decode (
    .i_sign(dec_sign),
    .i_exp(dec_exp),
    .i_man(dec_man),
    .o_f32(dec_f32)
  );

  // single precision input fields
  wire f_sign;
  wire [7:0] f_exp;
  wire [22:0] f_man;
  wire f_nan;
  wire f_inf;
  assign f_sign = i_data[31];
  assign f_exp = i_data[30:23];
  assign f_man = i_data[22:0];
  assign f_nan = (f_exp == `F32_EXP_SPECIAL) && (f_man != 23'h0);
  assign f_inf = (f_exp == `F32_EXP_SPECIAL) && (f_man == 23'h0);

  // encode to unsigned eleven-bit or ten-bit float
  integer es;
  integer ex;
  integer mw;
  integer drop;
  integer sh;
  reg [63:0] sig;
  reg [63:0] rnd;
  reg [63:0] mn;
  reg [63:0] code;
  reg [10:0] enc_small;
  reg is11;

  always @* begin
    is11 = (i_op == `OP_UF11_ENC);
    mw = is11 ? `UF11_MAN_W : `UF10_MAN_W;
    drop = `F32_MAN_W - mw;
    es = f_exp - `SMALL_REBIAS;
    sh = (es >= 1) ? 0 : (1 - es);
    sig = 64'h0;
    rnd = 64'h0;
    mn = 64'h0;
    code = 64'h0;
    ex = 0;
    enc_small = 11'h000;
    if (f_nan) begin
      enc_small = is11 ? `UF11_NAN : {1'b0, `UF10_NAN}; // RULE10
    end else if (f_sign) begin
      enc_small = 11'h000; // RULE7 RULE10
    end else if (f_inf) begin
      enc_small = is11 ? `UF11_POS_INF : {1'b0, `UF10_POS_INF}; // RULE10
    end else if (f_exp == 8'h00 || sh > 30) begin
      enc_small = 11'h000;
    end else if (es > `SMALL_EXP_MAX_FINITE) begin
      enc_small = is11 ? `UF11_MAX_FINITE : {1'b0, `UF10_MAX_FINITE}; // RULE8 RULE9
    end else begin
      sig = {40'h0, 1'b1, f_man} >> sh;
      rnd = (sig + (64'h1 << (drop - 1))) >> drop; // RULE7
      mn = rnd & ((64'h1 << mw) - 64'h1);
      if (es >= 1) begin
        ex = rnd[mw + 1] ? es + 1 : es;
        if (rnd[mw + 1]) begin
          mn = 64'h0;
        end
      end else begin
        ex = rnd[mw] ? 1 : 0; // RULE6 RULE11
      end
      code = (ex << mw) | mn;
      if (ex > `SMALL_EXP_MAX_FINITE) begin
        enc_small = is11 ? `UF11_MAX_FINITE : {1'b0, `UF10_MAX_FINITE}; // RULE8 RULE9
      end else begin
        enc_small = code[10:0];
      end
    end
  end

  // 16.16 fixed to float
  wire [31:0] fix_mag;
  wire [31:0] fix_f32;
  assign fix_mag = i_data[31] ? (32'h0 - i_data) : i_data; // RULE12
  assign fix_f32 = mag_to_f32(fix_mag, i_data[31], `FIX_FRAC_BITS); // RULE12

  // normalized integers to float
  reg [31:0] un_c;
  reg [31:0] un_f32;
  reg [31:0] sn_c;
  reg [31:0] sn_mag;
  reg [31:0] sn_half;
  reg sn_neg;
  reg [31:0] sn_f32;

  always @* begin
    un_c = i_data & mask_u; // RULE17
    if (un_c == mask_u) begin
      un_f32 = `F32_ONE; // RULE14 RULE18
    end else begin
      un_f32 = mag_to_f32(rep_frac(un_c, w_u), 1'b0, `NORM_FRAC_BITS); // RULE14
    end
    sn_c = i_data & mask_s;
    sn_half = mask_s_w[32:1] + 32'h1;
    sn_neg = ((sn_c & sn_half) != 32'h0);
    sn_mag = sn_neg ? ((~sn_c + 32'h1) & mask_s) : sn_c;
    if (sn_mag == 32'h0) begin
      sn_f32 = 32'h0; // RULE18
    end else if (sn_neg && sn_mag == sn_half) begin
      sn_f32 = `F32_NEG_ONE; // RULE15
    end else if (sn_mag == sn_half - 32'h1) begin
      sn_f32 = sn_neg ? `F32_NEG_ONE : `F32_ONE; // RULE15
    end else begin
      sn_f32 = mag_to_f32(rep_frac(sn_mag, w_s - 5'h01), sn_neg, `NORM_FRAC_BITS); // RULE15
    end
  end

  // float to normalized integers
  reg [32:0] fx;
  reg [4:0] nb;
  reg [63:0] prod;
  reg [63:0] rmag;
  reg [31:0] norm_int;

  always @* begin
    if (f_nan || f_exp == 8'h00) begin
      fx = 33'h0;
    end else if (f_exp >= `F32_BIAS) begin
      fx = 33'h100000000; // RULE20 RULE21
    end else begin
      fx = {1'b1, f_man, 9'h000} >> (`F32_BIAS - f_exp);
    end
    if (i_op == `OP_F_TO_UNORM && f_sign) begin
      fx = 33'h0; // RULE20
    end
    nb = (i_op == `OP_F_TO_UNORM) ? w_u : (w_s - 5'h01);
    prod = ({31'h0, fx} << nb) - {31'h0, fx}; // RULE20 RULE21
    rmag = (prod + `ROUND_HALF) >> 32; // RULE22
    if (i_op == `OP_F_TO_UNORM) begin
      norm_int = rmag[31:0] & mask_u; // RULE20
    end else if (f_sign) begin
      norm_int = (32'h0 - rmag[31:0]) & mask_s; // RULE21
    end else begin
      norm_int = rmag[31:0] & mask_s; // RULE21
    end
  end

  // float to 16.16 fixed, truncating toward zero and saturating
  reg [63:0] fxv;
  reg [31:0] to_fix;

  always @* begin
    fxv = {40'h0, 1'b1, f_man};
    if (f_exp >= 8'h86) begin
      fxv = fxv << (f_exp - 8'h86);
    end else begin
      fxv = fxv >> (8'h86 - f_exp);
    end
    if (f_nan || f_exp == 8'h00) begin
      to_fix = 32'h0;
    end else if (f_exp >= `FIX_SAT_EXP) begin
      to_fix = f_sign ? `FIX_NEG_MAX : `FIX_POS_MAX;
    end else if (f_sign) begin
      to_fix = 32'h0 - fxv[31:0];
    end else begin
      to_fix = fxv[31:0];
    end
  end

  // result select
  always @* begin
    case (i_op)
      `OP_HALF_DEC: begin
        result_nxt = dec_f32; // RULE1 RULE2
      end
      `OP_UF11_DEC: begin
        result_nxt = dec_f32; // RULE5
      end
      `OP_UF10_DEC: begin
        result_nxt = dec_f32; // RULE11
      end
      `OP_UF11_ENC: begin
        result_nxt = {21'h0, enc_small};
      end
      `OP_UF10_ENC: begin
        result_nxt = {22'h0, enc_small[9:0]};
      end
      `OP_FIX_TO_F: begin
        result_nxt = fix_f32;
      end
      `OP_UNORM_TO_F: begin
        result_nxt = un_f32;
      end
      `OP_SNORM_TO_F: begin
        result_nxt = sn_f32;
      end
      `OP_F_TO_UNORM: begin
        result_nxt = norm_int;
      end
      `OP_F_TO_SNORM: begin
        result_nxt = norm_int;
      end
      `OP_F_TO_FIX: begin
        result_nxt = to_fix; // RULE19
      end
      default: begin
        result_nxt = `RESULT_RST;
      end
    endcase
  end

  // fixed one-cycle latency for every input value, so no operand can stall the stage
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_valid_r <= 1'b0;
      o_result_r <= `RESULT_RST;
    end else begin
      o_valid_r <= i_valid; // RULE4 RULE13 RULE19
      if (i_valid) begin
        o_result_r <= result_nxt;
      end
    end
  end

  assign o_valid = o_valid_r;
  assign o_result = o_result_r;

endmodule
`default_nettype wire

//--- conv_monitor.sv
// concurrent checks on the converter ports
// assumes: bound to packed_float_fixed_converter, one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module conv_monitor (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_valid,
  input wire [3:0] i_op,
  input wire [31:0] i_data,
  input wire [4:0] i_width,
  input wire i_alpha_min2,
  input wire o_valid,
  input wire [31:0] o_result
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire f_nan = i_data[30:23] == 8'hff && i_data[22:0] != 23'h0;
  wire f_big = !i_data[31] && i_data[30:23] >= 8'h8f && i_data[30:23] != 8'hff;
  sequence take(code);
    i_valid && i_op == code;
  endsequence
  valid_pulse_a: assert property (i_valid |=> o_valid)
    else $error("result strobe missing");
  idle_hold_a: assert property (!i_valid |=> !o_valid && $stable(o_result))
    else $error("result moved while idle");
  half_one_a: assert property (take(4'h0) ##0 i_data[15:0] == 16'h3c00 |=> o_result == 32'h3f800000)
    else $error("half one decoded wrong");
  half_inf_a: assert property (take(4'h0) ##0 i_data[14:0] == 15'h7c00 |=>
    o_result == {$past(i_data[15]), 31'h7f800000}) else $error("half infinity decoded wrong");
  uf11_neg_a: assert property (take(4'h3) ##0 (i_data[31] && !f_nan) |=> o_result == 32'h0)
    else $error("negative value not zeroed");
  uf11_nan_a: assert property (take(4'h3) ##0 f_nan |=> o_result == 32'h7e0)
    else $error("nan not mapped to positive nan");
  uf11_sat_a: assert property (take(4'h3) ##0 f_big |=> o_result == 32'h7bf)
    else $error("eleven-bit encode not saturated");
  uf10_sat_a: assert property (take(4'h4) ##0 f_big |=> o_result == 32'h3df)
    else $error("ten-bit encode not saturated");
  unorm_top_a: assert property (take(4'h8) ##0 (i_data == 32'h3f800000 && i_width == 5'h08)
    |=> o_result == 32'hff) else $error("one not mapped to full code");
  alpha_floor_a: assert property (take(4'h6) ##0 (i_width == 5'h01 && i_alpha_min2 && i_data[1:0] == 2'h2)
    |=> o_result[31:23] == 9'h07e) else $error("alpha width not raised to two");
  reset_clear_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_valid && o_result == 32'h0)
    else $error("reset left output set");
endmodule
`default_nettype wire

//--- result_sink.sv
// downstream stage model: takes every result word the converter presents
// assumes: consumer never stalls, counts words across resets
`timescale 1ns/10ps
`default_nettype none
module result_sink (
  input wire i_clk,
  input wire i_valid,
  input wire [31:0] i_result,
  output logic [15:0] o_count,
  output logic [31:0] o_last
);
  initial o_count = 16'h0;
  always @(posedge i_clk) begin
    if (i_valid) begin
      o_count <= o_count + 16'h1;
      o_last <= i_result;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the float/fixed converter
// assumes: one cycle latency, one operation per cycle, no stall
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clk, i_sys_rst, i_valid, i_alpha_min2;
  logic [3:0] i_op;
  logic [31:0] i_data;
  logic [4:0] i_width;
  wire o_valid;
  wire [31:0] o_result;
  wire [15:0] sink_count;
  wire [31:0] sink_last;
  int miscompares = 0;
  int n_checks = 0;
  int issued = 0;
  packed_float_fixed_converter i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_op(i_op),
    .i_data(i_data), .i_width(i_width), .i_alpha_min2(i_alpha_min2), .o_valid(o_valid), .o_result(o_result));
  result_sink i_sink (.i_clk(i_clk), .i_valid(o_valid), .i_result(o_result), .o_count(sink_count),
    .o_last(sink_last));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task run(input [3:0] op, input [31:0] d, input [31:0] exp);
    i_valid = 1'b1;
    i_op = op;
    i_data = d;
    issued++;
    @(posedge i_clk);
    #1;
    chk({31'h0, o_valid}, 32'h1);
    chk(o_result, exp);
  endtask
  task t_half;
    run(4'h0, 32'h3c00, 32'h3f800000);
    run(4'h0, 32'h8000, 32'h80000000);
    run(4'h0, 32'h0001, 32'h33800000);
    run(4'h0, 32'h7bff, 32'h477fe000);
    run(4'h0, 32'hfc00, 32'hff800000);
    run(4'h0, 32'h7c01, 32'h7fc02000);
    run(4'h0, 32'h12343c00, 32'h3f800000);
    $display("half decode done");
  endtask
  task t_small;
    run(4'h1, 32'h3c0, 32'h3f800000);
    run(4'h1, 32'h001, 32'h35800000);
    run(4'h1, 32'h7bf, 32'h477e0000);
    run(4'h1, 32'h7c0, 32'h7f800000);
    run(4'h2, 32'h1e0, 32'h3f800000);
    run(4'h2, 32'h001, 32'h36000000);
    run(4'h2, 32'h3df, 32'h477c0000);
    $display("small decode done");
  endtask
  task t_enc;
    run(4'h3, 32'h3f800000, 32'h3c0);
    run(4'h3, 32'h3f818000, 32'h3c1);
    run(4'h3, 32'hbf800000, 32'h0);
    run(4'h3, 32'h47800000, 32'h7bf);
    run(4'h3, 32'h7f800000, 32'h7c0);
    run(4'h3, 32'hff800000, 32'h0);
    run(4'h3, 32'hffc00000, 32'h7e0);
    run(4'h4, 32'h3f830000, 32'h1e1);
    run(4'h4, 32'h47800000, 32'h3df);
    run(4'h4, 32'h7f800000, 32'h3e0);
    run(4'h4, 32'h7fc00000, 32'h3f0);
    $display("small encode done");
  endtask
  task t_fix;
    run(4'h5, 32'h00010000, 32'h3f800000);
    run(4'h5, 32'hffff0000, 32'hbf800000);
    run(4'h5, 32'h00008000, 32'h3f000000);
    run(4'ha, 32'h3f800000, 32'h00010000);
    run(4'ha, 32'h4e6e6b28, 32'h7fffffff);
    run(4'ha, 32'h80000000, 32'h0);
    $display("fixed done");
  endtask
  task t_norm;
    i_width = 5'h08;
    run(4'h6, 32'hff, 32'h3f800000);
    run(4'h6, 32'h1ff, 32'h3f800000);
    run(4'h7, 32'h81, 32'hbf800000);
    run(4'h7, 32'h80, 32'hbf800000);
    run(4'h7, 32'h0, 32'h0);
    run(4'h6, 32'h0, 32'h0);
    run(4'h8, 32'h3f800000, 32'hff);
    run(4'h8, 32'hbf800000, 32'h0);
    run(4'h8, 32'h3f000000, 32'h80);
    run(4'h9, 32'hc0000000, 32'h81);
    run(4'h9, 32'h3f000000, 32'h40);
    i_width = 5'h01;
    run(4'h6, 32'h1, 32'h3f800000);
    i_alpha_min2 = 1'b1;
    run(4'h6, 32'h1, 32'h3eaaaaaa);
    run(4'h6, 32'h2, 32'h3f2aaaaa);
    i_width = 5'h00;
    i_alpha_min2 = 1'b0;
    run(4'h6, 32'h1, 32'h3f800000);
    $display("normalized done");
  endtask
  task t_misc;
    run(4'hf, 32'h3c00, 32'h0);
    run(4'h0, 32'h3c00, 32'h3f800000);
    i_valid = 1'b0;
    i_data = 32'h0;
    repeat (3) @(posedge i_clk);
    #1;
    chk({31'h0, o_valid}, 32'h0);
    chk(o_result, 32'h3f800000);
    i_sys_rst = 1'b1;
    i_valid = 1'b1;
    @(posedge i_clk);
    #1;
    chk({31'h0, o_valid}, 32'h0);
    chk(o_result, 32'h0);
    i_sys_rst = 1'b0;
    i_valid = 1'b0;
    @(posedge i_clk);
    #1;
    chk({16'h0, sink_count}, issued);
    chk(sink_last, 32'h3f800000);
    $display("misc done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #16000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report;
  end
  initial begin
    i_sys_rst = 1'b1;
    i_valid = 1'b0;
    i_op = 4'h0;
    i_data = 32'h0;
    i_width = 5'h08;
    i_alpha_min2 = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    t_half;
    t_small;
    t_enc;
    t_fix;
    t_norm;
    t_misc;
    final_report;
  end
endmodule
bind packed_float_fixed_converter conv_monitor i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid),
  .i_op(i_op), .i_data(i_data), .i_width(i_width), .i_alpha_min2(i_alpha_min2), .o_valid(o_valid),
  .o_result(o_result));
`default_nettype wire
